// ### rtl/dsrp_pkg.sv
// constants and types of the dual serial register port
// assumes one core clock; the register file itself lives outside
package dsrp_pkg;
    // =========================================
    // two-wire bus addressing
    localparam logic [3:0] ADDR_FIXED = 4'h9;    // upper four address bits 1001
    localparam logic [2:0] ADDR_LO_LOW = 3'h0;   // select pin tied low
    localparam logic [2:0] ADDR_LO_FLOAT = 3'h2; // select pin floating
    localparam logic [2:0] ADDR_LO_HIGH = 3'h3;  // select pin tied high
    localparam logic [3:0] BIT_LAST = 4'h7;      // eighth bit of a byte
    localparam logic [3:0] BIT_ACK = 4'h8;       // ninth (acknowledge) bit
    localparam logic [1:0] WB_PTR = 2'h0;        // write byte index: pointer
    localparam logic [1:0] WB_DATA = 2'h2;       // first index with a byte behind
    localparam logic [1:0] WB_PEC = 2'h3;        // index where a check byte may sit
    localparam logic [7:0] CRC_POLY = 8'h07;     // x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_INIT = 8'h00;
    // =========================================
    // four-wire port
    localparam logic [7:0] CMD_WR = 8'h90;
    localparam logic [7:0] CMD_RD = 8'h91;
    localparam logic [7:0] PTR_WRAP = 8'h3F;
    localparam logic [7:0] PTR_FIRST = 8'h00;
    localparam logic [7:0] LOCK_STAT_ADDR = 8'h7F;
    localparam logic [1:0] LOCK_PULSES = 2'h3;
    localparam logic [1:0] SB_CMD = 2'h0;        // byte index: command
    localparam logic [1:0] SB_PTR = 2'h1;        // byte index: pointer
    localparam logic [1:0] SB_DATA = 2'h2;       // byte index: data (saturates)
    // =========================================
    // pins: scl, sda, select, sclk, din, addr high, addr float
    localparam int NPIN = 7;
    localparam logic [6:0] PIN_IDLE = 7'h70;     // bus lines idle high
    // =========================================
    // timing
    localparam int TOUT_MS = 25;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TOUT_CYC = TOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 16;
    // =========================================
    // two-wire engine states
    typedef enum logic [1:0] {
        TW_IDLE = 2'b00,
        TW_ADDR = 2'b01,
        TW_WRITE = 2'b10,
        TW_READ = 2'b11
    } dsrp_tw_e;
endpackage

// ### rtl/dsrp_top.sv
// dual serial register port: two-wire slave and four-wire slave
// assumes an outside register file fed by the write stream and
// answering RD_DATA combinationally for RD_ADDR on the same clock
`timescale 1ns/1ps

module dsrp_top #(
    parameter int unsigned TOUT_CYCLES = dsrp_pkg::TOUT_CYC,
    parameter int unsigned FIFO_DEPTH = dsrp_pkg::FIFO_D
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic ADDR_PIN_HIGH,
    input wire logic ADDR_PIN_FLOAT,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    output logic DOUT_OUT,
    output logic DOUT_OE,
    input wire logic TIMEOUT_EN,
    output logic SPI_LOCKED,
    output logic WR_VALID,
    input wire logic WR_READY,
    output logic [7:0] WR_ADDR,
    output logic [7:0] WR_DATA,
    output logic [7:0] RD_ADDR,
    input wire logic [7:0] RD_DATA
);
    import dsrp_pkg::*;

    localparam int TW = $clog2(TOUT_CYCLES + 1);

    // =========================================
    // pin synchronisers
    logic [NPIN-1:0] s1; // first stage, read only by s2
    logic [NPIN-1:0] s2; // settled pin levels
    logic [NPIN-1:0] s3; // one cycle older, for edges

    // every pin is foreign to MCLK, so two flops before use
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
        end else begin
            s1 <= {SCL, SDA_IN, CS_N, SCLK, DIN, ADDR_PIN_HIGH, ADDR_PIN_FLOAT};
            s2 <= s1;
            s3 <= s2;
        end
    end

    logic scl, sda, cs_n, sclk, din, scl_q, sda_q, cs_q, sclk_q;
    assign {scl, sda, cs_n, sclk, din} = s2[6:2];
    assign {scl_q, sda_q, cs_q, sclk_q} = {s3[6:4], s3[3]};
    logic scl_rise, scl_fall, start, stop, cs_rise, cs_fall;
    logic sclk_rise, sclk_fall;
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    // data moving while clock stays high marks a frame edge
    assign start = ~sda & sda_q & scl & scl_q;
    assign stop = sda & ~sda_q & scl & scl_q;
    assign cs_rise = cs_n & ~cs_q;
    assign cs_fall = ~cs_n & cs_q;
    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;

    // =========================================
    // interface selection lock
    logic locked;       // four-wire mode held until power off
    logic [1:0] lock_cnt; // select pulses seen so far

    // only power-on reset clears it; no soft path exists
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            locked <= 1'b0;
            lock_cnt <= 2'h0;
        end else if (!locked && cs_rise) begin
            lock_cnt <= lock_cnt + 2'h1;
            if (lock_cnt == LOCK_PULSES - 2'h1) begin
                locked <= 1'b1;
            end
        end
    end
    assign SPI_LOCKED = locked;

    logic tw_on;
    assign tw_on = ~locked;

    // =========================================
    // shared pointer and read value
    logic [7:0] ptr;
    logic [7:0] ptr_next;
    logic [7:0] rd_value;
    assign ptr_next = (ptr == PTR_WRAP) ? PTR_FIRST : ptr + 8'h01;
    assign RD_ADDR = ptr;
    // lock status answered here, not by the register file
    assign rd_value = (ptr == LOCK_STAT_ADDR) ? {7'h00, locked} : RD_DATA;

    // =========================================
    // two-wire engine
    dsrp_tw_e tw_state;
    logic [3:0] bit_cnt;  // 0..7 data, 8 acknowledge
    logic [7:0] tw_sr;    // wire byte, also transmit shifter
    logic [1:0] wbytes;   // bytes after address, saturating
    logic ack_pend;       // device drives the next ack
    logic [7:0] crc;      // running check over the frame
    logic [7:0] pend;     // last data byte, held back
    logic [7:0] pend_crc; // check value before pend
    logic pend_v;
    logic seen_once, addr_held;
    logic [2:0] addr_lo, addr_live, addr_eff;
    logic [7:0] rx_byte;
    logic tw_done, tout_hit, fifo_rdy;
    logic tw_push, tw_commit, is_pec;

    assign rx_byte = {tw_sr[6:0], sda};
    assign tw_done = tw_on & scl_rise & (tw_state != TW_IDLE) & (bit_cnt == BIT_LAST);

    // three-state pin seen as two levels
    always_comb begin
        if (s2[0]) begin
            addr_live = ADDR_LO_FLOAT;
        end else if (s2[1]) begin
            addr_live = ADDR_LO_HIGH;
        end else begin
            addr_live = ADDR_LO_LOW;
        end
    end
    assign addr_eff = addr_held ? addr_lo : addr_live;

    // bytewise CRC-8, msb first
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // pin taken for good on the second matching address byte
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            seen_once <= 1'b0;
            addr_held <= 1'b0;
            addr_lo <= ADDR_LO_LOW;
        end else if (tw_done && tw_state == TW_ADDR && !addr_held
                     && rx_byte[7:1] == {ADDR_FIXED, addr_eff}) begin
            seen_once <= 1'b1;
            if (seen_once) begin
                addr_held <= 1'b1;
                addr_lo <= addr_live;
            end
        end
    end

    // byte sequencing, direction and check accumulation
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tw_state <= TW_IDLE;
            bit_cnt <= 4'h0;
            tw_sr <= 8'h00;
            wbytes <= WB_PTR;
            ack_pend <= 1'b0;
            crc <= CRC_INIT;
            pend <= 8'h00;
            pend_crc <= CRC_INIT;
            pend_v <= 1'b0;
        end else if (!tw_on || tout_hit || stop) begin
            // abandon; next frame starts clean
            tw_state <= TW_IDLE;
            ack_pend <= 1'b0;
            crc <= CRC_INIT;
            pend_v <= 1'b0;
        end else if (start) begin
            // repeated start keeps the check running
            tw_state <= TW_ADDR;
            bit_cnt <= 4'h0;
            wbytes <= WB_PTR;
            ack_pend <= 1'b0;
            pend_v <= 1'b0;
        end else if (scl_rise && tw_state != TW_IDLE) begin
            if (bit_cnt == BIT_ACK) begin
                bit_cnt <= 4'h0;
                ack_pend <= 1'b0;
                if (tw_state == TW_READ) begin
                    if (!ack_pend && sda) begin
                        tw_state <= TW_IDLE;
                    end else begin
                        // first the register, then the check byte
                        tw_sr <= ack_pend ? rd_value : crc;
                    end
                end
            end else begin
                tw_sr <= rx_byte;
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == BIT_LAST) begin
                    crc <= crc8(crc, rx_byte);
                    case (tw_state)
                        TW_ADDR: begin
                            if (rx_byte[7:1] == {ADDR_FIXED, addr_eff}) begin
                                ack_pend <= 1'b1;
                                tw_state <= rx_byte[0] ? TW_READ : TW_WRITE;
                            end else begin
                                tw_state <= TW_IDLE;
                            end
                        end
                        TW_WRITE: begin
                            // full buffer is refused by a nack
                            ack_pend <= (wbytes == WB_PTR) | fifo_rdy;
                            if (wbytes != WB_PEC) begin
                                wbytes <= wbytes + 2'h1;
                            end
                            if (wbytes != WB_PTR) begin
                                pend <= rx_byte;
                                pend_crc <= crc;
                                pend_v <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // a held byte equal to the check of what preceded it is the check
    assign is_pec = (wbytes == WB_PEC) & (pend == pend_crc);
    assign tw_commit = tw_on & pend_v & (start | stop) & ~is_pec & ~tout_hit;
    assign tw_push = (tw_done & tw_state == TW_WRITE & wbytes >= WB_DATA & pend_v)
                   | tw_commit;

    // open-drain data line, changed on falling clock or released at once by lock, timeout, start or stop
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            SDA_OE <= 1'b0;
        end else if (!tw_on || tout_hit || start || stop) begin
            SDA_OE <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt == BIT_ACK) begin
                SDA_OE <= ack_pend;
            end else begin
                SDA_OE <= (tw_state == TW_READ) & ~tw_sr[7];
            end
        end
    end
    assign SDA_OUT = 1'b0;

    // idle watchdog, runs only inside a frame
    logic [TW-1:0] tout_cnt;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tout_cnt <= '0;
        end else if (!TIMEOUT_EN || tw_state == TW_IDLE || scl != scl_q || sda != sda_q) begin
            tout_cnt <= '0;
        end else begin
            tout_cnt <= tout_cnt + TW'(1);
        end
    end
    assign tout_hit = TIMEOUT_EN & (tout_cnt == TW'(TOUT_CYCLES - 1));

    // =========================================
    // four-wire engine
    logic spi_act;
    logic [2:0] spi_cnt;
    logic [7:0] spi_sr;
    logic [7:0] spi_rx;
    logic [1:0] spi_bytes;
    logic [7:0] spi_cmd;
    logic [7:0] tx;
    logic tx_load, spi_done, spi_push, spi_ptr_ld, spi_adv;
    assign spi_act = locked & ~cs_n;
    assign spi_rx = {spi_sr[6:0], din};
    assign spi_done = spi_act & sclk_rise & (spi_cnt == BIT_LAST[2:0]);
    assign spi_ptr_ld = spi_done & spi_bytes == SB_PTR & spi_cmd == CMD_WR;
    assign spi_push = spi_done & spi_bytes == SB_DATA & spi_cmd == CMD_WR;
    assign spi_adv = spi_push | (spi_done & spi_bytes != SB_CMD & spi_cmd == CMD_RD);

    // inputs taken on rising sclk; select fall opens a frame
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            spi_cnt <= 3'h0;
            spi_sr <= 8'h00;
            spi_bytes <= SB_CMD;
            spi_cmd <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            tx_load <= spi_done & (spi_bytes == SB_CMD ? spi_rx == CMD_RD
                                                       : spi_cmd == CMD_RD);
            if (locked && cs_fall) begin
                spi_cnt <= 3'h0;
                spi_bytes <= SB_CMD;
                spi_cmd <= 8'h00;
            end else if (spi_act && sclk_rise) begin
                spi_sr <= spi_rx;
                spi_cnt <= spi_cnt + 3'h1;
                if (spi_done) begin
                    if (spi_bytes == SB_CMD) begin
                        spi_cmd <= spi_rx;
                    end
                    if (spi_bytes != SB_DATA) begin
                        spi_bytes <= spi_bytes + 2'h1;
                    end
                end
            end
        end
    end

    // output shifter, moves on falling sclk
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tx <= 8'h00;
            DOUT_OUT <= 1'b0;
        end else if (tx_load) begin
            tx <= rd_value; // pointer already advanced, except on the load after the command byte
        end else if (spi_act && sclk_fall) begin
            DOUT_OUT <= tx[7];
            tx <= {tx[6:0], 1'b0};
        end
    end
    assign DOUT_OE = spi_act;

    // pointer loads from either port, advances on four-wire only
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ptr <= PTR_FIRST;
        end else if (tw_done && tw_state == TW_WRITE && wbytes == WB_PTR) begin
            ptr <= rx_byte;
        end else if (spi_ptr_ld) begin
            ptr <= spi_rx;
        end else if (spi_adv) begin
            ptr <= ptr_next;
        end
    end

    // =========================================
    // write stream buffer
    logic push_v;
    logic [FIFO_W-1:0] push_d;
    assign push_v = tw_push | spi_push;
    assign push_d = tw_push ? {ptr, pend} : {ptr, spi_rx};

    dsrp_fifo #(
        .W(FIFO_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RSTN),
        .in_valid(push_v),
        .in_ready(fifo_rdy),
        .in_data(push_d),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data({WR_ADDR, WR_DATA})
    );
endmodule

// flop-based queue; depth must be a power of two
module dsrp_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    logic do_w, do_r;
    assign in_ready = cnt != (AW+1)'(D);
    assign out_valid = cnt != '0;
    assign do_w = in_valid & in_ready;
    assign do_r = out_valid & out_ready;
    assign out_data = mem[rp];

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (do_w) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= wp + AW'(do_w);
            rp <= rp + AW'(do_r);
            cnt <= cnt + (AW+1)'(do_w) - (AW+1)'(do_r);
        end
    end
endmodule

// ### testbench/dsrp_chk_sva.sv
// checker for the dual serial register port
// sees only the top ports; one core clock domain
`timescale 1ns/1ps
module dsrp_chk #(
    parameter int unsigned TOUT_CYCLES = dsrp_pkg::TOUT_CYC,
    parameter int unsigned FIFO_DEPTH = 16
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic SCL,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DOUT_OUT,
    input wire logic DOUT_OE,
    input wire logic SPI_LOCKED,
    input wire logic WR_VALID,
    input wire logic WR_READY,
    input wire logic [7:0] WR_ADDR,
    input wire logic [7:0] WR_DATA
);
    import dsrp_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // ========
    // named steps: a pin held for four core cycles, past the synchronisers
    sequence scl_high;
        SCL [*4];
    endsequence
    sequence sclk_high;
        SCLK [*4];
    endsequence
    sequence cs_idle;
        CS_N [*4];
    endsequence
    sequence spi_sel;
        (SPI_LOCKED && !CS_N) [*4];
    endsequence
    // ========
    // two-wire side
    od_low_a: assert property (SDA_OUT == 1'h0)
        else $error("data pin driven high");
    sda_move_a: assert property ($changed(SDA_OE) |-> !SCL)
        else $error("data drive moved while clock high");
    sda_hold_a: assert property (scl_high |-> $stable(SDA_OE))
        else $error("data drive unstable in clock high");
    // ========
    // four-wire side
    cs_release_a: assert property (cs_idle |-> !DOUT_OE)
        else $error("output driven while deselected");
    spi_drive_a: assert property (spi_sel |-> DOUT_OE)
        else $error("output not driven while selected");
    oe_lock_a: assert property (DOUT_OE |-> SPI_LOCKED)
        else $error("output driven before lock");
    lock_keep_a: assert property (SPI_LOCKED |=> SPI_LOCKED)
        else $error("lock dropped");
    dout_hold_a: assert property (sclk_high |-> $stable(DOUT_OUT))
        else $error("output moved while clock high");
    // write stream must wait for the register file
    wr_hold_a: assert property (WR_VALID && !WR_READY |=>
        WR_VALID && $stable({WR_ADDR, WR_DATA}))
        else $error("write stream changed while stalled");
endmodule

bind dsrp_top dsrp_chk #(.TOUT_CYCLES(TOUT_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk (
    .MCLK(MCLK), .RSTN(RSTN), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .CS_N(CS_N), .SCLK(SCLK), .DOUT_OUT(DOUT_OUT), .DOUT_OE(DOUT_OE),
    .SPI_LOCKED(SPI_LOCKED), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA)
);

// ### testbench/dsrp_host.sv
// bus host model for the dual serial register port
// paced by the core clock; data wire has a pull-up, serial clock idles low
`timescale 1ns/1ps
module dsrp_host (
    input wire logic mclk,
    input wire logic sda_oe,
    input wire logic dout,
    output logic scl,
    output logic sda,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    logic drv; // host pulls the data wire low
    // wired-and with pull-up: a released wire reads high
    assign sda = !(drv || sda_oe);
    initial begin
        scl = 1'h1;
        drv = 1'h0;
        cs_n = 1'h1;
        sclk = 1'h0;
        din = 1'h1;
    end
    // ========
    // two-wire bus
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        drv <= 1'h0;
        w(4);
        scl <= 1'h1;
        w(4);
        drv <= 1'h1;
        w(4);
        scl <= 1'h0;
        w(4);
    endtask
    // stop: data rises while clock high, also ends a read after its nak
    task automatic stop();
        drv <= 1'h1;
        w(4);
        scl <= 1'h1;
        w(4);
        drv <= 1'h0;
        w(8);
    endtask
    // eight bits then a released ninth bit; data moves only with clock low
    task automatic tx(input logic [7:0] d, output logic [7:0] r, output logic a);
        logic [8:0] s;
        logic [8:0] c;
        s = {d, 1'h1};
        for (int i = 0; i < 9; i++) begin
            drv <= !s[8 - i];
            w(4);
            scl <= 1'h1;
            w(4);
            c = {c[7:0], sda};
            w(4);
            scl <= 1'h0;
            w(4);
        end
        r = c[8:1];
        a = c[0];
    endtask
    // ========
    // four-wire port; host drives the data line high while idle
    task automatic sel(input logic s);
        cs_n <= s;
        din <= 1'h1;
        w(8);
    endtask
    // one byte MSB first; read bit taken late in the high phase
    task automatic sb(input logic [7:0] d, output logic [7:0] r);
        for (int i = 0; i < 8; i++) begin
            din <= d[7 - i];
            w(8);
            sclk <= 1'h1;
            w(7);
            r = {r[6:0], dout};
            w(1);
            sclk <= 1'h0;
        end
    endtask
endmodule

// ### testbench/dual_serial_register_port_tb.sv
// self-checking bench for the dual serial register port
// assumes dsrp_host as far side and a register file answering ~address
`timescale 1ns/1ps
module dual_serial_register_port_tb;
    import dsrp_pkg::*;
    // table row: select pin levels, address tried, expected ninth bit
    typedef struct packed {
        logic hi;
        logic fl;
        logic [6:0] ad;
        logic nak;
    } dsrp_row_s;
    logic mclk, rstn, scl, sda_in, sda_out, sda_oe, pin_hi, pin_fl;
    logic cs_n, sclk, din, dout, dout_oe, tout_en, locked, wr_valid, wr_ready;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, r;
    logic a;
    int fails, compares;
    logic [15:0] got[$], want[$];
    logic [7:0] rd[$], bq[$];
    dsrp_row_s rows[6] = '{'{1'h0, 1'h0, 7'h48, 1'h0}, '{1'h0, 1'h0, 7'h4A, 1'h1},
        '{1'h1, 1'h0, 7'h4B, 1'h0}, '{1'h1, 1'h0, 7'h48, 1'h1},
        '{1'h1, 1'h1, 7'h4A, 1'h0}, '{1'h0, 1'h1, 7'h4A, 1'h0}};
    // ========
    // clock, register file, write stream monitor
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    assign rd_data = ~rd_addr; // register value is its inverted address
    always @(posedge mclk)
        if (wr_valid && wr_ready) got.push_back({wr_addr, wr_data});
    dsrp_top #(.TOUT_CYCLES(200), .FIFO_DEPTH(FIFO_D)) uut (
        .MCLK(mclk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDR_PIN_HIGH(pin_hi), .ADDR_PIN_FLOAT(pin_fl), .CS_N(cs_n),
        .SCLK(sclk), .DIN(din), .DOUT_OUT(dout), .DOUT_OE(dout_oe), .TIMEOUT_EN(tout_en),
        .SPI_LOCKED(locked), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .RD_ADDR(rd_addr), .RD_DATA(rd_data));
    dsrp_host host (.mclk(mclk), .sda_oe(sda_oe), .dout(dout), .scl(scl), .sda(sda_in),
        .cs_n(cs_n), .sclk(sclk), .din(din));
    // ========
    // helpers
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // let the stream drain, then compare it whole
    task automatic cq();
        repeat (60) @(posedge mclk);
        chk("push count", 16'(got.size()), 16'(want.size()));
        foreach (want[i]) chk("push", got[i], want[i]);
        got.delete();
        want.delete();
    endtask
    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rst();
        rstn <= 1'h0;
        repeat (10) @(posedge mclk);
        rstn <= 1'h1;
        repeat (8) @(posedge mclk);
    endtask
    // address byte alone, then stop
    task automatic probe(input logic [7:0] b, input logic e);
        host.start();
        host.tx(b, r, a);
        host.stop();
        chk("addr ack", 16'(a), 16'(e));
    endtask
    // one select-low frame, keeping what came back
    task automatic sf(input logic [7:0] b[$]);
        rd.delete();
        host.sel(1'h0);
        foreach (b[i]) begin
            host.sb(b[i], r);
            rd.push_back(r);
        end
        host.sel(1'h1);
    endtask
    // check byte over three frame bytes, generator 07h
    function automatic logic [7:0] crc(input logic [23:0] m);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'h0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // ========
    // main sequence
    initial begin
        rstn = 1'h0;
        pin_hi = 1'h0;
        pin_fl = 1'h0;
        tout_en = 1'h0;
        wr_ready = 1'h1;
        foreach (rows[i]) begin
            pin_hi <= rows[i].hi;
            pin_fl <= rows[i].fl;
            rst();
            probe({rows[i].ad, 1'h0}, rows[i].nak);
        end
        chk("reset ptr", 16'(rd_addr), 16'h0000);
        // second valid write latches the pin; two data bytes hit one register
        host.start();
        host.tx(8'h94, r, a);
        host.tx(8'h15, r, a);
        host.tx(8'hA5, r, a);
        host.tx(8'h5C, r, a);
        host.stop();
        want = '{16'h15A5, 16'h155C};
        cq();
        probe(8'h94, 1'h0);
        // a fresh start is needed: a bare byte after stop is ignored by the idle engine
        host.start();
        host.tx(8'h94, r, a);
        host.tx(8'h22, r, a);
        host.stop();
        cq();
        chk("ptr only", 16'(rd_addr), 16'h0022);
        // pointer then repeated start into a read; host naks and stops
        host.start();
        host.tx(8'h94, r, a);
        host.tx(8'h30, r, a);
        host.start();
        host.tx(8'h95, r, a);
        chk("rd addr ack", 16'(a), 16'h0000);
        host.tx(8'hFF, r, a);
        host.stop();
        chk("rd data", 16'(r), 16'h00CF);
        chk("rd release", 16'(sda_oe), 16'h0000);
        pin_fl <= 1'h0;
        probe(8'h90, 1'h1);
        // idle past the abort count, then the pointer byte is ignored
        tout_en <= 1'h1;
        probe(8'h94, 1'h0);
        host.start();
        host.tx(8'h94, r, a);
        repeat (300) @(posedge mclk);
        host.tx(8'h40, r, a);
        host.stop();
        tout_en <= 1'h0;
        chk("timeout nak", 16'(a), 16'h0001);
        chk("timeout ptr", 16'(rd_addr), 16'h0030);
        host.start();
        host.tx(8'h94, r, a);
        host.tx(8'h16, r, a);
        host.tx(8'h3C, r, a);
        host.tx(crc({8'h94, 8'h16, 8'h3C}), r, a);
        host.stop();
        want = '{16'h163C};
        cq();
        // three select pulses lock the four-wire port
        for (int i = 0; i < 3; i++) begin
            host.sel(1'h0);
            host.sel(1'h1);
            chk("lock", 16'(locked), 16'(i == 2));
        end
        chk("spi idle", 16'(dout_oe), 16'h0000);
        sf('{8'hA5, 8'h10, 8'h77});
        sf('{8'h90, 8'h7F});
        sf('{8'h91, 8'h00});
        chk("lock status", 16'(rd[1]), 16'h0001);
        sf('{8'h90, 8'h3F});
        sf('{8'h91, 8'h00, 8'h00});
        chk("read 3F", 16'(rd[1]), 16'h00C0);
        chk("read wrap", 16'(rd[2]), 16'h00FF);
        cq();
        // stalled stream: fill past depth, extra bytes are dropped
        wr_ready <= 1'h0;
        bq = '{8'h90, 8'h3E};
        for (int i = 0; i < 18; i++) begin
            bq.push_back(8'(i));
            if (i < FIFO_D) want.push_back({2'h0, 6'(6'h3E + i), 8'(i)});
        end
        sf(bq);
        wr_ready <= 1'h1;
        cq();
        conclude();
    end
    // watchdog: whole run needs roughly 9000 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule
